//--- trim_cfg.svh
// register map, reset values and timing figures for the trim block
// assumes a 50 MHz core clock and a 32-bit apb data path
`ifndef TRIM_CFG_SVH
`define TRIM_CFG_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define OFS_CELL_GAIN      12'h000
`define OFS_CELL_OFFSET    12'h004
`define OFS_CHAN_ENABLE    12'h008
`define OFS_DELAY_CTRL     12'h00C
`define OFS_DEVICE_CTRL    12'h010
`define OFS_KEY_ONE        12'h014
`define OFS_KEY_TWO        12'h018
`define OFS_STATUS         12'h01C
`define OFS_XOFF_BASE      12'h020
`define OFS_XOFF_LAST      12'h03C

// ------------------------------------------------------------------
// widths, field positions and reset values
// ------------------------------------------------------------------
`define RES_W              16
`define CELL_TRIM_W        8
`define XOFF_TRIM_W        10
`define XOFF_REG_W         16
`define NUM_CELLS          16
`define NUM_XIN            8
`define CHAN_W             4
`define DELAY_BIT          0
`define NV_WRITE_BIT       0
`define RST_CHAN_ENABLE    16'hFFFF
`define RST_TRIM8          8'h00
`define RST_TRIM16         16'h0000

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define CLK_MHZ            50
`define FE_DELAY_US        100

`endif

//--- trim_pkg.sv
// types shared by the trim block and its helpers
// assumes trim_cfg.svh supplies every width
`include "trim_cfg.svh"

package trim_pkg;

  // ----------------------------------------------------------------
  // conversion result carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 aux;  // extra sensor input, not a cell
    logic [`CHAN_W-1:0]   idx;  // channel number
    logic [`RES_W-1:0]    data; // unsigned result
  } conv_result_t;

  // ----------------------------------------------------------------
  // sampling sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_START = 2'b10,
    ST_WAIT  = 2'b11
  } seq_state_t;

endpackage : trim_pkg

//--- delay_timer.sv
// one-shot cycle counter for the front-end start delay
// assumes a start pulse on the same clock; done is a one-cycle pulse
`include "trim_cfg.svh"

module delay_timer #(
  parameter int unsigned CYCLES = 5000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic i_start,
  output logic      o_done
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          done_ff;
  logic          nxt_done;

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  // zero means idle, so a restart while running simply reloads
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (i_start) begin
      nxt_cnt = CW'(CYCLES);
    end else if (cnt_ff != '0) begin
      nxt_cnt  = cnt_ff - CW'(1);
      nxt_done = (cnt_ff == CW'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign o_done = done_ff;

endmodule : delay_timer

//--- trim_apply.sv
// gain and offset correction of one conversion result, one cycle deep
// assumes the input is already factory corrected; output is clamped
`include "trim_cfg.svh"

module trim_apply import trim_pkg::*; #(
  parameter int GW = `CELL_TRIM_W,
  parameter int OW = `XOFF_TRIM_W
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // raw result and trims
  input  wire logic                 i_valid,
  input  conv_result_t              i_res,
  input  wire logic signed [GW-1:0] i_gain,
  input  wire logic signed [OW-1:0] i_offset,
  // corrected result
  output logic                      o_valid,
  output conv_result_t              o_res
);
  localparam int PW = `RES_W + 1 + GW;
  localparam int SW = `RES_W + 3;

  logic signed [PW-1:0] prod;
  logic signed [SW-1:0] sum;
  conv_result_t         nxt_res;
  conv_result_t         res_ff;
  logic                 valid_ff;

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // gain is in lsb at full scale, so it scales with the input level
  always_comb begin
    prod    = $signed({1'b0, i_res.data}) * i_gain;
    sum     = SW'(prod >>> `RES_W)
            + SW'($signed({1'b0, i_res.data}))
            + SW'(i_offset);
    nxt_res = res_ff;
    if (i_valid) begin
      nxt_res = i_res;
      // clamp instead of letting a trim wrap a near-rail reading
      if (sum[SW-1]) begin
        nxt_res.data = '0;
      end else if (|sum[SW-2:`RES_W]) begin
        nxt_res.data = '1;
      end else begin
        nxt_res.data = sum[`RES_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_ff   <= '0;
      valid_ff <= 1'b0;
    end else begin
      res_ff   <= nxt_res;
      valid_ff <= i_valid;
    end
  end

  assign o_valid = valid_ff;
  assign o_res   = res_ff;

endmodule : trim_apply

//--- cell_adc_trim_correction.sv
// trim registers, result correction and multiplexer sequencing
// assumes an apb master and a front end on I_CLK; results arrive
// after factory correction, one per I_CONV_VALID pulse
//
// Implementation choices: the register offsets and the APB interface to the registers.
`include "trim_cfg.svh"

// Functional notes
// - park mux on highest enabled cell, sample first
// - delay bit adds fixed wait before cell sampling
// - delay bit change applies after next sample
// - cell trims global, never on extra inputs
// - user trims follow factory corrections
// - trims signed; zero means no correction
// - gain trim 8-bit signed, 255 steps
// - gain correction proportional to input level
// - cell offset 8-bit signed, added uniformly
// - extra inputs offset only, each own trim
// - extra trim 10-bit signed in 16-bit register
// - zero extra trim leaves result unchanged
// - keys then nv write bit; host redoes checksum
module cell_adc_trim_correction import trim_pkg::*; #(
  parameter int unsigned DELAY_CYCLES = `FE_DELAY_US * `CLK_MHZ,
  parameter logic [31:0] KEY_ONE      = 32'h0000_1357, // arbitrary value
  parameter logic [31:0] KEY_TWO      = 32'h0000_2468  // arbitrary value
) (
  // clock and reset
  input  wire logic               I_CLK,
  input  wire logic               I_RST_N,
  // apb slave
  input  wire logic               I_PSEL,
  input  wire logic               I_PENABLE,
  input  wire logic               I_PWRITE,
  input  wire logic [11:0]        I_PADDR,
  input  wire logic [31:0]        I_PWDATA,
  output logic [31:0]             O_PRDATA,
  output logic                    O_PREADY,
  output logic                    O_PSLVERR,
  // sampling control toward the front end
  input  wire logic               I_SAMPLE_REQ,
  output logic                    O_CONV_START,
  output logic [`CHAN_W-1:0]      O_MUX_CHAN,
  // factory corrected conversion results
  input  wire logic               I_CONV_VALID,
  input  conv_result_t            I_CONV_RES,
  // user corrected results
  output logic                    O_RESULT_VALID,
  output conv_result_t            O_RESULT,
  // request to the nonvolatile storage engine
  output logic                    O_NV_STORE
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [`CELL_TRIM_W-1:0] gain_ff;
  logic [`CELL_TRIM_W-1:0] nxt_gain;
  logic [`CELL_TRIM_W-1:0] coff_ff;
  logic [`CELL_TRIM_W-1:0] nxt_coff;
  logic [`NUM_CELLS-1:0]   en_ff;
  logic [`NUM_CELLS-1:0]   nxt_en;
  logic                    dly_req_ff;
  logic                    nxt_dly_req;
  logic                    dly_eff_ff;
  logic                    nxt_dly_eff;
  logic [31:0]             key1_ff;
  logic [31:0]             nxt_key1;
  logic [31:0]             key2_ff;
  logic [31:0]             nxt_key2;
  logic                    nv_store_ff;
  logic                    nxt_nv_store;
  logic [`XOFF_REG_W-1:0]  xoff_ff [`NUM_XIN];
  logic [`XOFF_REG_W-1:0]  nxt_xoff [`NUM_XIN];
  logic [31:0]             prdata_ff;
  logic [31:0]             nxt_prdata;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic                    setup_ph;
  logic                    access_ph;
  logic                    wr_en;
  logic                    xoff_hit;
  logic [2:0]              xoff_idx;
  logic                    addr_hit;
  logic                    unlocked;
  logic [31:0]             rd_data;

  // zero wait states: every access completes in its first access cycle
  assign setup_ph  = I_PSEL & ~I_PENABLE;
  assign access_ph = I_PSEL & I_PENABLE;
  assign wr_en     = access_ph & I_PWRITE;
  assign xoff_hit  = (I_PADDR >= `OFS_XOFF_BASE) && (I_PADDR <= `OFS_XOFF_LAST)
                   && (I_PADDR[1:0] == 2'b00);
  assign xoff_idx  = I_PADDR[4:2];
  assign unlocked  = (key1_ff == KEY_ONE) && (key2_ff == KEY_TWO);

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  seq_state_t              state_ff;
  seq_state_t              nxt_state;
  logic [`CHAN_W-1:0]      chan_ff;
  logic [`CHAN_W-1:0]      nxt_chan;
  logic                    tmr_start;
  logic                    tmr_done;
  logic                    cell_done;
  logic [`CHAN_W:0]        top_pick;
  logic [`CHAN_W:0]        low_pick;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unmapped words read zero and raise pslverr in the access phase
  always_comb begin
    rd_data  = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (I_PADDR)
      `OFS_CELL_GAIN:   rd_data[`CELL_TRIM_W-1:0] = gain_ff;
      `OFS_CELL_OFFSET: rd_data[`CELL_TRIM_W-1:0] = coff_ff;
      `OFS_CHAN_ENABLE: rd_data[`NUM_CELLS-1:0]   = en_ff;
      `OFS_DELAY_CTRL:  rd_data[`DELAY_BIT]       = dly_req_ff;
      `OFS_DEVICE_CTRL: rd_data                   = 32'h0000_0000;
      `OFS_KEY_ONE:     rd_data                   = key1_ff;
      `OFS_KEY_TWO:     rd_data                   = key2_ff;
      `OFS_STATUS: begin
        rd_data[0]   = (state_ff != ST_IDLE);
        rd_data[1]   = dly_eff_ff;
        rd_data[2]   = unlocked;
        rd_data[7:4] = chan_ff;
      end
      default: begin
        if (xoff_hit) begin
          rd_data[`XOFF_REG_W-1:0] = xoff_ff[xoff_idx];
        end else begin
          addr_hit = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    nxt_gain     = gain_ff;
    nxt_coff     = coff_ff;
    nxt_en       = en_ff;
    nxt_dly_req  = dly_req_ff;
    nxt_key1     = key1_ff;
    nxt_key2     = key2_ff;
    nxt_xoff     = xoff_ff;
    nxt_nv_store = 1'b0;
    nxt_prdata   = setup_ph ? rd_data : prdata_ff;
    if (wr_en) begin
      unique case (I_PADDR)
        `OFS_CELL_GAIN:   nxt_gain    = I_PWDATA[`CELL_TRIM_W-1:0];
        `OFS_CELL_OFFSET: nxt_coff    = I_PWDATA[`CELL_TRIM_W-1:0];
        `OFS_CHAN_ENABLE: nxt_en      = I_PWDATA[`NUM_CELLS-1:0];
        `OFS_DELAY_CTRL:  nxt_dly_req = I_PWDATA[`DELAY_BIT];
        `OFS_KEY_ONE:     nxt_key1    = I_PWDATA;
        `OFS_KEY_TWO:     nxt_key2    = I_PWDATA;
        `OFS_DEVICE_CTRL: begin
          // store only with both keys loaded; keys then re-lock
          nxt_nv_store = I_PWDATA[`NV_WRITE_BIT] & unlocked;
          nxt_key1     = 32'h0000_0000;
          nxt_key2     = 32'h0000_0000;
        end
        default: begin
          if (xoff_hit) begin
            nxt_xoff[xoff_idx] = I_PWDATA[`XOFF_REG_W-1:0];
          end
        end
      endcase
    end
  end

  // delay bit is taken over only once a front-end sample finishes
  always_comb begin
    nxt_dly_eff = I_CONV_VALID ? dly_req_ff : dly_eff_ff;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      gain_ff     <= `RST_TRIM8;
      coff_ff     <= `RST_TRIM8;
      en_ff       <= `RST_CHAN_ENABLE;
      dly_req_ff  <= 1'b0;
      dly_eff_ff  <= 1'b0;
      key1_ff     <= 32'h0000_0000;
      key2_ff     <= 32'h0000_0000;
      nv_store_ff <= 1'b0;
      prdata_ff   <= 32'h0000_0000;
      for (int i = 0; i < `NUM_XIN; i++) begin
        xoff_ff[i] <= `RST_TRIM16;
      end
    end else begin
      gain_ff     <= nxt_gain;
      coff_ff     <= nxt_coff;
      en_ff       <= nxt_en;
      dly_req_ff  <= nxt_dly_req;
      dly_eff_ff  <= nxt_dly_eff;
      key1_ff     <= nxt_key1;
      key2_ff     <= nxt_key2;
      nv_store_ff <= nxt_nv_store;
      prdata_ff   <= nxt_prdata;
      xoff_ff     <= nxt_xoff;
    end
  end

  // ----------------------------------------------------------------
  // channel search
  // ----------------------------------------------------------------
  // returns {found, index} of the highest enabled cell below a limit
  function automatic logic [`CHAN_W:0] pick_below(
    input logic [`NUM_CELLS-1:0] en,
    input logic [`CHAN_W:0]      lim
  );
    logic [`CHAN_W:0] r;
    r = '0;
    for (int i = 0; i < `NUM_CELLS; i++) begin
      if (en[i] && (i < int'(lim))) begin
        r = {1'b1, `CHAN_W'(i)};
      end
    end
    return r;
  endfunction : pick_below

  assign top_pick  = pick_below(en_ff, (`CHAN_W+1)'(`NUM_CELLS));
  assign low_pick  = pick_below(en_ff, {1'b0, chan_ff});
  assign cell_done = I_CONV_VALID & ~I_CONV_RES.aux;

  // ----------------------------------------------------------------
  // sampling sequencer
  // ----------------------------------------------------------------
  // cells are walked from the highest enabled one downward
  always_comb begin
    nxt_state = state_ff;
    nxt_chan  = chan_ff;
    tmr_start = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (top_pick[`CHAN_W]) begin
          nxt_chan = top_pick[`CHAN_W-1:0];
        end
        if (I_SAMPLE_REQ && top_pick[`CHAN_W]) begin
          if (dly_eff_ff) begin
            tmr_start = 1'b1;
            nxt_state = ST_DELAY;
          end else begin
            nxt_state = ST_START;
          end
        end
      end
      ST_DELAY: begin
        if (tmr_done) begin
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (cell_done) begin
          if (low_pick[`CHAN_W]) begin
            nxt_chan  = low_pick[`CHAN_W-1:0];
            nxt_state = ST_START;
          end else begin
            // back to parking so the next cycle opens on this channel
            nxt_chan  = top_pick[`CHAN_W-1:0];
            nxt_state = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_ff <= ST_IDLE;
      chan_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      chan_ff  <= nxt_chan;
    end
  end

  delay_timer #(
    .CYCLES (DELAY_CYCLES)
  ) u_delay (
    .clk     (I_CLK),
    .rst_n   (I_RST_N),
    .i_start (tmr_start),
    .o_done  (tmr_done)
  );

  // ----------------------------------------------------------------
  // trim selection
  // ----------------------------------------------------------------
  logic signed [`CELL_TRIM_W-1:0] sel_gain;
  logic signed [`XOFF_TRIM_W-1:0] sel_off;
  logic [`XOFF_REG_W-1:0]         xoff_word;

  // upper six bits of an extra trim word are ignored
  always_comb begin
    xoff_word = xoff_ff[I_CONV_RES.idx[2:0]];
    if (I_CONV_RES.aux) begin
      sel_gain = '0;
      sel_off  = $signed(xoff_word[`XOFF_TRIM_W-1:0]);
    end else begin
      sel_gain = $signed(gain_ff);
      sel_off  = `XOFF_TRIM_W'($signed(coff_ff));
    end
  end

  // input already carries factory corrections; user trims go on top
  trim_apply #(
    .GW (`CELL_TRIM_W),
    .OW (`XOFF_TRIM_W)
  ) u_trim (
    .clk      (I_CLK),
    .rst_n    (I_RST_N),
    .i_valid  (I_CONV_VALID),
    .i_res    (I_CONV_RES),
    .i_gain   (sel_gain),
    .i_offset (sel_off),
    .o_valid  (O_RESULT_VALID),
    .o_res    (O_RESULT)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign O_PRDATA     = prdata_ff;
  assign O_PREADY     = 1'b1;
  assign O_PSLVERR    = access_ph & ~addr_hit;
  assign O_CONV_START = (state_ff == ST_START);
  assign O_MUX_CHAN   = chan_ff;
  assign O_NV_STORE   = nv_store_ff;

endmodule : cell_adc_trim_correction

//--- trim_props.sv
// port assertions for the trim correction block
// assumes it is bound into cell_adc_trim_correction, one clock domain
`include "trim_cfg.svh"

module trim_props import trim_pkg::*; #(
  parameter int unsigned DELAY_CYCLES = 5000
) (
  // clock and reset
  input wire logic              I_CLK,
  input wire logic              I_RST_N,
  // apb slave
  input wire logic              I_PSEL,
  input wire logic              I_PENABLE,
  input wire logic              I_PWRITE,
  input wire logic [11:0]       I_PADDR,
  input wire logic [31:0]       I_PWDATA,
  input wire logic [31:0]       O_PRDATA,
  input wire logic              O_PREADY,
  input wire logic              O_PSLVERR,
  // sampling and results
  input wire logic              I_SAMPLE_REQ,
  input wire logic              O_CONV_START,
  input wire logic [`CHAN_W-1:0] O_MUX_CHAN,
  input wire logic              I_CONV_VALID,
  input conv_result_t           I_CONV_RES,
  input wire logic              O_RESULT_VALID,
  input conv_result_t           O_RESULT,
  input wire logic              O_NV_STORE
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic access;
  logic cell_done;
  logic bad_addr;
  logic nv_write;

  // decoded events; a cell result is what moves the sequencer on
  assign access    = I_PSEL && I_PENABLE;
  assign cell_done = I_CONV_VALID && !I_CONV_RES.aux;
  assign bad_addr  = (I_PADDR > `OFS_XOFF_LAST) || (I_PADDR[1:0] != 2'b00);
  assign nv_write  = access && I_PWRITE && (I_PADDR == `OFS_DEVICE_CTRL) && I_PWDATA[0];

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  park_after_reset_a: assert property ($rose(I_RST_N) |=> O_MUX_CHAN == 4'hF)
    else $error("mux not parked on top cell after reset");
  mux_hold_a: assert property (O_CONV_START && !cell_done |=> $stable(O_MUX_CHAN))
    else $error("mux moved before the cell result");
  start_cause_a: assert property (O_CONV_START |-> $past(I_SAMPLE_REQ)
    || $past(I_SAMPLE_REQ, DELAY_CYCLES + 2) || $past(cell_done))
    else $error("conversion start without cause");
  start_pulse_a: assert property (O_CONV_START |=> !O_CONV_START)
    else $error("conversion start longer than one cycle");
  result_route_a: assert property (I_CONV_VALID |=> O_RESULT_VALID
    && O_RESULT.aux == $past(I_CONV_RES.aux) && O_RESULT.idx == $past(I_CONV_RES.idx))
    else $error("result late or on wrong channel");
  result_cause_a: assert property (O_RESULT_VALID |-> $past(I_CONV_VALID))
    else $error("result without input");
  nv_cause_a: assert property (O_NV_STORE |-> $past(nv_write))
    else $error("store request without control write");
  nv_pulse_a: assert property (O_NV_STORE |=> !O_NV_STORE)
    else $error("store request longer than one cycle");
  bad_addr_a: assert property (access && bad_addr |-> O_PREADY && O_PSLVERR)
    else $error("unmapped access not flagged");

  // main scenarios
  cover property (O_NV_STORE);
  cover property (O_CONV_START ##1 !O_CONV_START);
  cover property (access && bad_addr);
endmodule : trim_props

bind cell_adc_trim_correction trim_props #(.DELAY_CYCLES(DELAY_CYCLES)) trim_props_i (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_SAMPLE_REQ(I_SAMPLE_REQ),
  .O_CONV_START(O_CONV_START), .O_MUX_CHAN(O_MUX_CHAN), .I_CONV_VALID(I_CONV_VALID),
  .I_CONV_RES(I_CONV_RES), .O_RESULT_VALID(O_RESULT_VALID), .O_RESULT(O_RESULT),
  .O_NV_STORE(O_NV_STORE));

//--- tb_top.sv
// self-checking bench for the trim correction block
// assumes the design and trim_props are compiled first
`include "trim_cfg.svh"

module tb_top import trim_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int          DLY = 8;            // short delay for simulation
  localparam logic [31:0] K1  = 32'h0000_0A5C; // arbitrary key value
  localparam logic [31:0] K2  = 32'h0000_03E1; // arbitrary key value
  logic              clk, rst_n, psel, pen, pwr, req, cv;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, start, rv, nv;
  logic [3:0]        mux;
  conv_result_t      cres, res;
  logic signed [7:0] gain, off;
  logic [15:0]       xt [8];
  int                fail_count, total_checks, seed, nv_cnt, i;

  cell_adc_trim_correction #(.DELAY_CYCLES(DLY), .KEY_ONE(K1), .KEY_TWO(K2))
    cell_adc_trim_correction_i (
    .I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_SAMPLE_REQ(req), .O_CONV_START(start), .O_MUX_CHAN(mux),
    .I_CONV_VALID(cv), .I_CONV_RES(cres), .O_RESULT_VALID(rv), .O_RESULT(res),
    .O_NV_STORE(nv));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // count store pulses as they pass
  always @(posedge clk) begin
    if (nv === 1'b1) nv_cnt++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (k == 16) begin
      chk(1'b0, 1'b1);
      report_and_stop();
    end
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
    chk(e, ee);
  endtask : rd_chk

  // corrected result: gain scales with input, offset flat, then clamp
  function automatic logic [15:0] exp_res(input logic a, input logic [2:0] n,
                                          input logic [15:0] x);
    int y;
    if (a) y = int'(x) + int'($signed(xt[n][9:0]));
    else y = int'(x) + ((int'(gain) * int'(x)) >>> 16) + int'(off);
    if (y < 0) y = 0;
    if (y > 65535) y = 65535;
    return y[15:0];
  endfunction : exp_res

  task automatic conv(input logic a, input logic [3:0] n, input logic [15:0] x);
    cv   <= 1'b1;
    cres <= '{aux: a, idx: n, data: x};
    @(posedge clk);
    cv <= 1'b0;
    #1;
    chk(rv, 1);
    chk(res, {a, n, exp_res(a, n[2:0], x)});
  endtask : conv

  task automatic set_trims(input int t);
    logic [31:0] r;
    int          k;
    r = $random(seed);
    if (t == 1) r[15:0] = 16'h7F7F;
    if (t == 7) r[15:0] = 16'h8080;
    gain = r[7:0];
    off  = r[15:8];
    wr(`OFS_CELL_GAIN, r);
    wr(`OFS_CELL_OFFSET, r >> 8);
    rd_chk(`OFS_CELL_GAIN, {24'h0, gain}, 1'b0);
    rd_chk(`OFS_CELL_OFFSET, {24'h0, off}, 1'b0);
    for (k = 0; k < 8; k++) begin
      r = $random(seed);
      if (t == 1) r[9:0] = 10'h1FF;
      if (t == 7) r[9:0] = 10'h200;
      xt[k] = r[15:0];
      wr(`OFS_XOFF_BASE + 12'(k * 4), r);
      rd_chk(`OFS_XOFF_BASE + 12'(k * 4), {16'h0, xt[k]}, 1'b0);
    end
  endtask : set_trims

  // one acquisition over the enabled cells, an extra result slipped in before each cell result
  task automatic acq(input logic [15:0] en, input logic dly, input int n_exp);
    int c;
    int top;
    int n;
    wr(`OFS_DELAY_CTRL, {31'h0, dly});
    wr(`OFS_CHAN_ENABLE, {16'h0, en});
    for (c = 0; c < 16; c++) if (en[c]) top = c;
    @(posedge clk);
    #1;
    chk(mux, top);
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    #1;
    for (n = 0; n < 40 && start !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk(n, n_exp);
    if (n == 40) report_and_stop();
    for (c = 15; c >= 0; c--) begin
      if (en[c]) begin
        chk(mux, c);
        chk(start, 1);
        @(posedge clk);
        conv(1'b1, {1'b0, c[2:0]}, 16'($random(seed)));
        chk({start, mux}, {1'b0, 4'(c)});
        @(posedge clk);
        conv(1'b0, 4'(c), 16'($random(seed)));
      end
    end
    chk({start, mux}, {1'b0, 4'(top)});
    @(posedge clk);
  endtask : acq

  task automatic nv_try(input int exp);
    int c0;
    c0 = nv_cnt;
    wr(`OFS_DEVICE_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk(nv_cnt - c0, exp);
  endtask : nv_try

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h5792_4393;
    {rst_n, psel, pen, pwr, req, cv} = '0;
    {paddr, pwdata, cres, gain, off} = '0;
    {fail_count, total_checks, nv_cnt} = '0;
    for (i = 0; i < 8; i++) xt[i] = 16'h0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values; unmapped word flagged
    for (i = 0; i < 16; i++) begin
      if (i < 5 || i > 7) rd_chk(12'(i * 4), (i == 2) ? 32'hFFFF : 32'h0, 1'b0);
    end
    wr(12'h040, 32'hFFFF_FFFF);
    rd_chk(12'h040, 32'h0000_0000, 1'b1);
    $display("test register reset done");
    // corrections: zero trims first, then random and extreme trims
    for (i = 0; i < 24; i++) begin
      @(posedge clk);
      if (i % 6 == 4) set_trims(i - 3);
      conv(i[0], {1'b0, i[3:1]}, (i % 3 == 0) ? 16'hFFFF :
           (i % 3 == 1) ? 16'h0000 : 16'h6666 + 15'($random(seed)));
    end
    @(posedge clk);
    $display("test correction done");
    // parking, order and the late-taking start delay
    for (i = 0; i < 3; i++) begin
      acq((i == 0) ? 16'h0025 : (16'($random(seed)) | 16'h0001), i == 0,
          (i == 1) ? DLY + 1 : 0);
    end
    $display("test sequencing done");
    // store request needs both keys, and keys are used up
    wr(`OFS_KEY_ONE, K1);
    wr(`OFS_KEY_TWO, K2);
    nv_try(1);
    nv_try(0);
    wr(`OFS_KEY_ONE, K1 ^ 32'h1);
    wr(`OFS_KEY_TWO, K2);
    nv_try(0);
    $display("test store done");
    report_and_stop();
  end
endmodule : tb_top
